// ==== src/fdcsr_consts.vh ====
// What this block does
// - Writing 1 to the calibrate bit starts self-calibration; it reads 0 while running and 1 when done, done cleared only at reset and at a (re)start.
// - Reads of the output level code return the latest calibration result, not the written value.
// - The light-load save enable bit turns power-save off at 0 and on at 1, reset value 1.
// - Reads of bit 5 of register 5 return the live level of camera strobe line b.
// - Writes to bit 5 of register 5 set the general-purpose pin direction, 1 output; the field resets to 1, gpioOe to 0 until the first clock after reset.
// - The port value bit is the driven value when the pin is an output and the sampled pin level when it is an input.
// - The temperature monitor enable bit turns sensing on at 1, reset value 0.
// - The over-temperature flag sets when the sense voltage is below the hot threshold and stays until software writes 0.
// - A set over-temperature flag forces shutdown until software clears the flag.
// - The warning flag sets below the warning threshold and is cleared by a read of its register.
// - The headroom bit is updated at the end of each flash strobe, 0 low and 1 sufficient.
// - Writes to the output level code set the regulation target, reset value 1001.
`ifndef FDCSR_CONSTS_VH
`define FDCSR_CONSTS_VH
`define FDCSR_ADDR_CAL      8'h05
`define FDCSR_ADDR_TMP      8'h06
`define FDCSR_CAL_BIT       7
`define FDCSR_PSM_BIT       6
`define FDCSR_DIR_BIT       5
`define FDCSR_GPV_BIT       4
`define FDCSR_GPT_BIT       3
`define FDCSR_LEDC_BIT      2
`define FDCSR_LEDB_BIT      1
`define FDCSR_LEDA_BIT      0
`define FDCSR_TSE_BIT       7
`define FDCSR_HOT_BIT       6
`define FDCSR_WRN_BIT       5
`define FDCSR_HDR_BIT       4
`define FDCSR_CAL_RST       8'h6A
`define FDCSR_TMP_RST       8'h09
`define FDCSR_CAL_TIME_NS   1000
`define FDCSR_CLK_NS        8
`define FDCSR_CAL_CYCLES    (`FDCSR_CAL_TIME_NS / `FDCSR_CLK_NS)
`endif

// ==== src/fdcsr_sync.v ====
`timescale 1ns/1ps
module fdcsr_sync #(
	parameter W = 1
) (
	input  wire         ref_clk,
	input  wire         arst_n,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] stage_reg;
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage_reg <= {W{1'b0}};
			dout      <= {W{1'b0}};
		end else begin
			stage_reg <= din;
			dout      <= stage_reg;
		end
	end
endmodule

// ==== src/fdcsr_regs.v ====
`timescale 1ns/1ps
`include "fdcsr_consts.vh"
module fdcsr_regs #(
	parameter CAL_CYCLES = `FDCSR_CAL_CYCLES
) (
	input  wire       ref_clk,
	input  wire       arst_n,
	input  wire [7:0] regAddr,
	input  wire [7:0] regWdata,
	input  wire       regWr,
	input  wire       regRd,
	output reg  [7:0] regRdata,
	input  wire       strobeLineB,
	input  wire       flashStrobe,
	input  wire       headroomIn,
	input  wire       tsBelowHot,
	input  wire       tsBelowWarn,
	input  wire [3:0] calResult,
	input  wire       gpioIn,
	output reg        gpioOut,
	output reg        gpioOe,
	output reg        gpioPushPull,
	output reg        lightLoadSaveOn,
	output reg        channelAOn,
	output reg        channelBOn,
	output reg        channelCOn,
	output reg        tempMonitorOn,
	output reg        shutdownOut,
	output reg        calRunning,
	output reg  [3:0] targetCode
);
	// ------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------
	wire [5:0] syn;
	fdcsr_sync #(.W(6)) uSync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.din     ({strobeLineB, flashStrobe, headroomIn, tsBelowHot, tsBelowWarn, gpioIn}),
		.dout    (syn)
	);
	wire strbS  = syn[5];
	wire flashS = syn[4];
	wire hdrS   = syn[3];
	wire hotS   = syn[2];
	wire warnS  = syn[1];
	wire gpioS  = syn[0];

	// ------------------------------------------------
	// Reset values and helpers
	// ------------------------------------------------
	localparam [7:0] CAL_RST = `FDCSR_CAL_RST;
	localparam [7:0] TMP_RST = `FDCSR_TMP_RST;

	// Address match for one register
	function addrHit;
		input [7:0] addr;
		input [7:0] base;
		begin
			addrHit = (addr == base);
		end
	endfunction

	// Sticky flag, a set event wins over a clear in the same cycle
	function flagNext;
		input cur;
		input setEv;
		input clrEv;
		begin
			if (setEv)
				flagNext = 1'b1;
			else if (clrEv)
				flagNext = 1'b0;
			else
				flagNext = cur;
		end
	endfunction

	// Port value as read back, driven level or sampled pin
	function portValue;
		input dirOut;
		input driven;
		input sampled;
		begin
			portValue = dirOut ? driven : sampled;
		end
	endfunction

	// ------------------------------------------------
	// Register state
	// ------------------------------------------------
	reg        calDone_reg;
	reg        calRun_reg;
	reg [15:0] calCnt_reg;
	reg [3:0]  calRes_reg;
	reg        dir_reg;
	reg        gpv_reg;
	reg        gpt_reg;
	reg        psm_reg;
	reg [2:0]  led_reg;
	reg        tse_reg;
	reg        hot_reg;
	reg        wrn_reg;
	reg        hdr_reg;
	reg [3:0]  ov_reg;
	reg        flashPrev_reg;

	// ------------------------------------------------
	// Access strobes and events
	// ------------------------------------------------
	wire selCal   = addrHit(regAddr, `FDCSR_ADDR_CAL);
	wire selTmp   = addrHit(regAddr, `FDCSR_ADDR_TMP);
	wire wrCal    = regWr && selCal;
	wire wrTmp    = regWr && selTmp;
	wire rdTmp    = regRd && selTmp;
	wire calStart = wrCal && regWdata[`FDCSR_CAL_BIT];
	wire flashEnd = flashPrev_reg && !flashS;
	wire hotSet   = tse_reg && hotS;
	wire hotClr   = wrTmp && !regWdata[`FDCSR_HOT_BIT];
	wire wrnSet   = tse_reg && warnS;
	wire hot_next = flagNext(hot_reg, hotSet, hotClr);
	wire wrn_next = flagNext(wrn_reg, wrnSet, rdTmp);

	// ------------------------------------------------
	// Self-calibration sequencer
	// ------------------------------------------------
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			calDone_reg <= 1'b0;
			calRun_reg  <= 1'b0;
			calCnt_reg  <= 16'h0000;
			calRes_reg  <= TMP_RST[3:0];
		end else begin
			if (calStart) begin
				calRun_reg  <= 1'b1;
				calDone_reg <= 1'b0;
				calCnt_reg  <= CAL_CYCLES[15:0];
			end else if (calRun_reg) begin
				if (calCnt_reg <= 16'h0001) begin
					calRun_reg  <= 1'b0;
					calDone_reg <= 1'b1;
					calRes_reg  <= calResult;
				end else begin
					calCnt_reg <= calCnt_reg - 16'h0001;
				end
			end
		end
	end

	// ------------------------------------------------
	// Control fields
	// ------------------------------------------------
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			psm_reg <= CAL_RST[`FDCSR_PSM_BIT];
			dir_reg <= CAL_RST[`FDCSR_DIR_BIT];
			gpv_reg <= CAL_RST[`FDCSR_GPV_BIT];
			gpt_reg <= CAL_RST[`FDCSR_GPT_BIT];
			led_reg <= CAL_RST[`FDCSR_LEDC_BIT:`FDCSR_LEDA_BIT];
			tse_reg <= TMP_RST[`FDCSR_TSE_BIT];
			ov_reg  <= TMP_RST[3:0];
		end else begin
			if (wrCal) begin
				psm_reg <= regWdata[`FDCSR_PSM_BIT];
				dir_reg <= regWdata[`FDCSR_DIR_BIT];
				gpv_reg <= regWdata[`FDCSR_GPV_BIT];
				gpt_reg <= regWdata[`FDCSR_GPT_BIT];
				led_reg <= regWdata[`FDCSR_LEDC_BIT:`FDCSR_LEDA_BIT];
			end
			if (wrTmp) begin
				tse_reg <= regWdata[`FDCSR_TSE_BIT];
				ov_reg  <= regWdata[3:0];
			end
		end
	end

	// ------------------------------------------------
	// Status flags
	// ------------------------------------------------
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hot_reg       <= TMP_RST[`FDCSR_HOT_BIT];
			wrn_reg       <= TMP_RST[`FDCSR_WRN_BIT];
			hdr_reg       <= TMP_RST[`FDCSR_HDR_BIT];
			flashPrev_reg <= 1'b0;
		end else begin
			flashPrev_reg <= flashS;
			hot_reg       <= hot_next;
			wrn_reg       <= wrn_next;
			if (flashEnd)
				hdr_reg <= hdrS;
		end
	end

	// ------------------------------------------------
	// Read data
	// ------------------------------------------------
	reg [7:0] rdData_next;
	always @* begin
		rdData_next = 8'h00;
		case (regAddr)
			`FDCSR_ADDR_CAL: begin
				rdData_next[`FDCSR_CAL_BIT]  = calDone_reg;
				rdData_next[`FDCSR_PSM_BIT]  = psm_reg;
				rdData_next[`FDCSR_DIR_BIT]  = strbS;
				rdData_next[`FDCSR_GPV_BIT]  = portValue(dir_reg, gpv_reg, gpioS);
				rdData_next[`FDCSR_GPT_BIT]  = gpt_reg;
				rdData_next[`FDCSR_LEDC_BIT] = led_reg[2];
				rdData_next[`FDCSR_LEDB_BIT] = led_reg[1];
				rdData_next[`FDCSR_LEDA_BIT] = led_reg[0];
			end
			`FDCSR_ADDR_TMP: begin
				rdData_next[`FDCSR_TSE_BIT] = tse_reg;
				rdData_next[`FDCSR_HOT_BIT] = hot_reg;
				rdData_next[`FDCSR_WRN_BIT] = wrn_reg;
				rdData_next[`FDCSR_HDR_BIT] = hdr_reg;
				rdData_next[3:0]            = calRes_reg;
			end
			default: begin
				rdData_next = 8'h00;
			end
		endcase
	end

	// ------------------------------------------------
	// Registered outputs
	// ------------------------------------------------
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata        <= 8'h00;
			gpioOut         <= CAL_RST[`FDCSR_GPV_BIT];
			gpioOe          <= 1'b0;
			gpioPushPull    <= CAL_RST[`FDCSR_GPT_BIT];
			lightLoadSaveOn <= CAL_RST[`FDCSR_PSM_BIT];
			channelAOn      <= 1'b0;
			channelBOn      <= 1'b0;
			channelCOn      <= 1'b0;
			tempMonitorOn   <= TMP_RST[`FDCSR_TSE_BIT];
			shutdownOut     <= TMP_RST[`FDCSR_HOT_BIT];
			calRunning      <= 1'b0;
			targetCode      <= TMP_RST[3:0];
		end else begin
			if (regRd)
				regRdata <= rdData_next;
			gpioOut         <= gpv_reg;
			gpioOe          <= dir_reg;
			gpioPushPull    <= gpt_reg;
			lightLoadSaveOn <= psm_reg;
			channelAOn      <= led_reg[0] && !hot_reg;
			channelBOn      <= led_reg[1] && !hot_reg;
			channelCOn      <= led_reg[2] && !hot_reg;
			tempMonitorOn   <= tse_reg;
			shutdownOut     <= hot_reg;
			calRunning      <= calRun_reg;
			targetCode      <= ov_reg;
		end
	end
endmodule

// ==== bench/fdcsr_asserts.sv ====
`timescale 1ns/1ps
module fdcsr_asserts (
	input wire logic       ref_clk,
	input wire logic       arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	input wire logic       gpioOe,
	input wire logic       gpioPushPull,
	input wire logic       lightLoadSaveOn,
	input wire logic       channelAOn,
	input wire logic       channelBOn,
	input wire logic       channelCOn,
	input wire logic       shutdownOut,
	input wire logic       calRunning,
	input wire logic [3:0] targetCode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire w5 = regWr && regAddr == 8'h05;
	wire w6 = regWr && regAddr == 8'h06;
	psm_write_a: assert property (w5 |=> ##1 lightLoadSaveOn == $past(regWdata[6], 2)) else $error("psm");
	dir_write_a: assert property (w5 |=> ##1 gpioOe == $past(regWdata[5], 2)) else $error("dir");
	type_write_a: assert property (w5 |=> ##1 gpioPushPull == $past(regWdata[3], 2)) else $error("type");
	target_write_a: assert property (w6 |=> ##1 targetCode == $past(regWdata[3:0], 2)) else $error("target");
	shutdown_gate_a: assert property (shutdownOut[*3] |-> !(channelAOn | channelBOn | channelCOn)) else $error("gate");
	hot_clear_a: assert property ($fell(shutdownOut) |-> $past(w6 && !regWdata[6], 2)) else $error("hot");
	cal_start_a: assert property ($rose(calRunning) |-> $past(w5 && regWdata[7], 2)) else $error("cal start");
	cal_end_a: assert property ($rose(calRunning) |-> ##[1:12] !calRunning) else $error("cal end");
	unmapped_read_a: assert property (regRd && (regAddr < 8'h05 || regAddr > 8'h06) |=> regRdata == 8'h00) else $error("map");
endmodule

// ==== bench/fdcsr_pin_model.sv ====
`timescale 1ns/1ps
module fdcsr_pin_model (
	input wire logic gpioOut,
	input wire logic gpioOe,
	input wire logic padLevel,
	output logic     gpioIn
);
	// Pin level seen by the block
	assign gpioIn = gpioOe ? gpioOut : padLevel;
endmodule

// ==== bench/flash_driver_ctrl_status_regs_tb_top.sv ====
`timescale 1ns/1ps
module flash_driver_ctrl_status_regs_tb_top;
	logic       ref_clk = 1'h0, arst_n = 1'h0, regWr = 1'h0, regRd = 1'h0, padLevel = 1'h1;
	logic       strobeLineB = 1'h1, flashStrobe = 1'h0, headroomIn = 1'h0, tsBelowHot = 1'h0, tsBelowWarn = 1'h0;
	logic       gpioIn, gpioOut, gpioOe, gpioPushPull, lightLoadSaveOn, channelAOn, channelBOn, channelCOn;
	logic       tempMonitorOn, shutdownOut, calRunning;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
	logic [3:0] calResult = 4'h5, targetCode;
	int         failures = 0, checked = 0;
	fdcsr_regs #(
		.CAL_CYCLES (8)
	) u_fdcsr_regs (
		.ref_clk         (ref_clk),
		.arst_n          (arst_n),
		.regAddr         (regAddr),
		.regWdata        (regWdata),
		.regWr           (regWr),
		.regRd           (regRd),
		.regRdata        (regRdata),
		.strobeLineB     (strobeLineB),
		.flashStrobe     (flashStrobe),
		.headroomIn      (headroomIn),
		.tsBelowHot      (tsBelowHot),
		.tsBelowWarn     (tsBelowWarn),
		.calResult       (calResult),
		.gpioIn          (gpioIn),
		.gpioOut         (gpioOut),
		.gpioOe          (gpioOe),
		.gpioPushPull    (gpioPushPull),
		.lightLoadSaveOn (lightLoadSaveOn),
		.channelAOn      (channelAOn),
		.channelBOn      (channelBOn),
		.channelCOn      (channelCOn),
		.tempMonitorOn   (tempMonitorOn),
		.shutdownOut     (shutdownOut),
		.calRunning      (calRunning),
		.targetCode      (targetCode)
	);
	fdcsr_pin_model u_fdcsr_pin_model (
		.gpioOut  (gpioOut),
		.gpioOe   (gpioOe),
		.padLevel (padLevel),
		.gpioIn   (gpioIn)
	);
	initial forever #4 ref_clk = ~ref_clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic idle;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk) {regWr, regAddr, regWdata} = {1'h1, a, d};
		@(negedge ref_clk) regWr = 1'h0;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk) {regRd, regAddr} = {1'h1, a};
		@(negedge ref_clk) regRd = 1'h0;
		chk(regRdata, exp);
	endtask
	task automatic results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#20000;
		failures++;
		results;
	end
	initial begin
		repeat (8) @(negedge ref_clk);
		arst_n = 1'h1;
		idle;
		rd(8'h05, 8'h6A);
		rd(8'h06, 8'h09);
		chk({gpioOe, gpioPushPull, lightLoadSaveOn, channelBOn, targetCode}, 8'hF9);
		wr(8'h06, 8'h83);
		chk({3'h0, tempMonitorOn, targetCode}, 8'h13);
		wr(8'h05, 8'hEA);
		rd(8'h05, 8'h6A);
		chk({7'h00, calRunning}, 8'h01);
		idle;
		idle;
		rd(8'h05, 8'hEA);
		rd(8'h06, 8'h85);
		strobeLineB = 1'h0;
		wr(8'h05, 8'h57);
		rd(8'h05, 8'hD7);
		chk({3'h0, gpioOe, gpioPushPull, channelAOn, channelCOn, gpioOut}, 8'h07);
		padLevel = 1'h0;
		strobeLineB = 1'h1;
		idle;
		rd(8'h05, 8'hE7);
		tsBelowWarn = 1'h1;
		idle;
		tsBelowWarn = 1'h0;
		idle;
		rd(8'h06, 8'hA5);
		rd(8'h06, 8'h85);
		tsBelowHot = 1'h1;
		idle;
		tsBelowHot = 1'h0;
		idle;
		rd(8'h06, 8'hC5);
		chk({5'h00, shutdownOut, channelAOn, channelCOn}, 8'h04);
		wr(8'h06, 8'h83);
		rd(8'h06, 8'h85);
		chk({5'h00, shutdownOut, channelAOn, channelCOn}, 8'h03);
		headroomIn = 1'h1;
		flashStrobe = 1'h1;
		idle;
		flashStrobe = 1'h0;
		idle;
		rd(8'h06, 8'h95);
		headroomIn = 1'h0;
		idle;
		rd(8'h06, 8'h95);
		rd(8'h07, 8'h00);
		results;
	end
endmodule
bind fdcsr_regs fdcsr_asserts u_fdcsr_asserts (
	.ref_clk         (ref_clk),
	.arst_n          (arst_n),
	.regAddr         (regAddr),
	.regWdata        (regWdata),
	.regWr           (regWr),
	.regRd           (regRd),
	.regRdata        (regRdata),
	.gpioOe          (gpioOe),
	.gpioPushPull    (gpioPushPull),
	.lightLoadSaveOn (lightLoadSaveOn),
	.channelAOn      (channelAOn),
	.channelBOn      (channelBOn),
	.channelCOn      (channelCOn),
	.shutdownOut     (shutdownOut),
	.calRunning      (calRunning),
	.targetCode      (targetCode)
);
